// *** inc/aec_pkg.sv ***
// aec_pkg: register map, field layout, encodings and bus carriers of the event counter
package aec_pkg;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTL_STATUS = 8'h00;
  localparam logic [7:0] OFS_CLK_CTL = 8'h04;
  localparam logic [7:0] OFS_EDGE_SEL = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;

  // ==========================================================================
  // field positions
  localparam int CS_HIGH_OVF = 7;
  localparam int CS_LOW_OVF = 6;
  localparam int CS_RSVD = 5;
  localparam int CS_CHAN = 4;
  localparam int CS_HIGH_CE = 3;
  localparam int CS_LOW_CE = 2;
  localparam int CS_HIGH_RC = 1;
  localparam int CS_LOW_RC = 0;
  localparam int CC_HIGH_SEL = 6;
  localparam int CC_LOW_SEL = 4;
  localparam int ES_HIGH_EDGE = 6;
  localparam int ES_LOW_EDGE = 4;
  localparam int ES_GATE_EDGE = 2;
  localparam int ES_PWM_EN = 0;
  localparam int IRQ_COUNT = 0;
  localparam int IRQ_GATE = 1;

  // ==========================================================================
  // reset values and counter maximum
  localparam logic [7:0] RST_CTL_STATUS = 8'h00;
  localparam logic [7:0] RST_CLK_CTL = 8'h00;
  localparam logic [7:0] RST_EDGE_SEL = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;

  // ==========================================================================
  // encodings
  localparam logic [1:0] CLK_SEL_PIN = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV2 = 2'h1;
  localparam logic [1:0] CLK_SEL_DIV4 = 2'h2;
  localparam logic [1:0] CLK_SEL_DIV8 = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam logic [7:0] GATE_IRQ_VECTOR = 8'h06;
  localparam logic [15:0] GATE_VEC_ADDR_HI = 16'h000C;
  localparam logic [15:0] GATE_VEC_ADDR_LO = 16'h000D;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } aec_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aec_axi_rsp_s;

  // bit 0 high event, 1 low event, 2 gate pin, 3 gate pwm output
  typedef struct packed {
    logic pwm;
    logic gate;
    logic low_event;
    logic high_event;
  } aec_pins_s;

endpackage

// *** hdl/aec_counter.sv ***
// aec_counter: dual 8-bit / cascaded 16-bit event counter with AXI4-Lite registers
// ============================================================================
// Notes on behaviour
// - high reset-control 0 holds high counter at zero; 1 lets it count
// - low reset-control 0 holds low counter at zero; 1 lets it count
// - overflow flags clear only by writing zero; writing one never sets
// - an overflow flag clears on zero write only after it was read as one
// - high counter is read-only 8-bit, alone or upper byte of 16 bits
// - high clock: high pin, clock/2, /4, /8, or low counter overflow
// - low counter is read-only 8-bit, alone or lower byte of 16 bits
// - each counter clears to zero through its own reset-control bit
// - channel select 0 cascades both counters into one 16-bit counter
// - 16-bit mode clocks from low select: clock/2, /4, /8 or low pin
// - low edge select picks which low pin edges count
// - after reset: 16-bit mode, low pin source, falling edges
// - 16-bit wrap from all ones to zero sets high overflow, keeps counting
// - any overflow sets interrupt flag; request goes out only when enabled
// - channel select 1 runs two independent 8-bit counters
// - 8-bit mode high select: clock/2, /4, /8 or high pin
// - 8-bit mode high edge select picks which high pin edges count
// - 8-bit high wrap to zero sets high overflow, keeps counting
// - 8-bit low wrap to zero sets low overflow, keeps counting
// - pwm gating off: both counters count only while gate pin is high
// - pwm gating on: both counters count only while pwm output is high
// - gate pin, or pwm output with pwm gating on, is also an interrupt source, vector six
// - low counter takes events only while its count enable is one; high counter does so only in 8-bit mode
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module aec_counter
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire aec_pkg::aec_axi_req_s axi_req_i,
  output aec_pkg::aec_axi_rsp_s axi_rsp_o,
  // pins
  input wire aec_pkg::aec_pins_s pins_i,
  // interrupt requests
  output logic counter_irq_o,
  output logic gate_irq_o,
  output logic [7:0] gate_irq_vector_o
);

  // ==========================================================================
  // helpers
  function automatic logic edge_hit(input logic [1:0] es, input logic r, input logic f);
    // codes 1x count both edges
    edge_hit = es[1] ? (r | f) : ((es == aec_pkg::EDGE_RISE) ? r : f);
  endfunction

  function automatic logic src_tick(input logic [1:0] sel, input logic pin_evt,
                                    input logic [2:0] pre);
    src_tick = 1'b0;
    unique case (sel)
      aec_pkg::CLK_SEL_PIN: src_tick = pin_evt;
      aec_pkg::CLK_SEL_DIV2: src_tick = pre[0];
      aec_pkg::CLK_SEL_DIV4: src_tick = &pre[1:0];
      aec_pkg::CLK_SEL_DIV8: src_tick = &pre;
    endcase
  endfunction

  // ==========================================================================
  // state
  logic [3:0] s1_q, s2_q, s3_q, filt_q, prev_q;
  logic [2:0] pre_q;
  logic hi_ovf_q, lo_ovf_q, rsvd_q, chan_q, hce_q, lce_q, hrc_q, lrc_q;
  logic hi_arm_q, lo_arm_q;
  logic [1:0] hsel_q, lsel_q, hedge_q, ledge_q, gedge_q;
  logic pwm_en_q;
  logic [7:0] cnt_hi_q, cnt_lo_q;
  logic cirq_q, girq_q, cen_q, gen_q;
  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q;
  logic arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] awaddr_q, wdata_q;
  logic wstrb_q;
  logic [31:0] rdata_q;

  // ==========================================================================
  // pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end
    else
    begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filt_q <= 4'h0;
      prev_q <= 4'h0;
    end
    else
    begin
      filt_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
      prev_q <= filt_q;
    end
  end

  logic [3:0] rise, fall;
  assign rise = filt_q & ~prev_q;
  assign fall = ~filt_q & prev_q;

  // ==========================================================================
  // prescaler
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pre_q <= 3'h0;
    else
      pre_q <= pre_q + 3'h1;
  end

  // ==========================================================================
  // bus write path
  logic aw_take, w_take, wr_do, aw_hold_d, w_hold_d, bvalid_d, wr_en;
  logic ar_take, rvalid_d;
  assign aw_take = axi_req_i.awvalid & awready_q;
  assign w_take = axi_req_i.wvalid & wready_q;
  assign wr_do = aw_hold_q & w_hold_q & ~bvalid_q;
  assign aw_hold_d = wr_do ? 1'b0 : (aw_hold_q | aw_take);
  assign w_hold_d = wr_do ? 1'b0 : (w_hold_q | w_take);
  assign bvalid_d = wr_do | (bvalid_q & ~axi_req_i.bready);
  assign wr_en = wr_do & wstrb_q;
  assign ar_take = axi_req_i.arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~axi_req_i.rready);

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == aec_pkg::OFS_CTL_STATUS) || (a == aec_pkg::OFS_CLK_CTL) ||
             (a == aec_pkg::OFS_EDGE_SEL) || (a == aec_pkg::OFS_COUNT_HIGH) ||
             (a == aec_pkg::OFS_COUNT_LOW) || (a == aec_pkg::OFS_IRQ_FLAG) ||
             (a == aec_pkg::OFS_IRQ_EN);
  endfunction

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= aec_pkg::AXI_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end
    else
    begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      // one write at a time: no new request while a response is pending
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q <= ~w_hold_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (aw_take)
        awaddr_q <= {axi_req_i.awaddr[7:2], 2'h0};
      if (w_take)
      begin
        wdata_q <= axi_req_i.wdata[7:0];
        wstrb_q <= axi_req_i.wstrb[0];
      end
      if (wr_do)
        bresp_q <= mapped(awaddr_q) ? aec_pkg::AXI_OKAY : aec_pkg::AXI_SLVERR;
    end
  end

  // ==========================================================================
  // bus read path
  logic [7:0] rd_byte;
  logic [7:0] rd_addr;
  assign rd_addr = {axi_req_i.araddr[7:2], 2'h0};

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (rd_addr)
      aec_pkg::OFS_CTL_STATUS:
        rd_byte = {hi_ovf_q, lo_ovf_q, rsvd_q, chan_q, hce_q, lce_q, hrc_q, lrc_q};
      aec_pkg::OFS_CLK_CTL: rd_byte = {hsel_q, lsel_q, 4'h0};
      aec_pkg::OFS_EDGE_SEL: rd_byte = {hedge_q, ledge_q, gedge_q, 1'b0, pwm_en_q};
      aec_pkg::OFS_COUNT_HIGH: rd_byte = cnt_hi_q;
      aec_pkg::OFS_COUNT_LOW: rd_byte = cnt_lo_q;
      aec_pkg::OFS_IRQ_FLAG: rd_byte = {6'h00, girq_q, cirq_q};
      aec_pkg::OFS_IRQ_EN: rd_byte = {6'h00, gen_q, cen_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= aec_pkg::AXI_OKAY;
    end
    else
    begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= mapped(rd_addr) ? aec_pkg::AXI_OKAY : aec_pkg::AXI_SLVERR;
      end
    end
  end

  assign axi_rsp_o = {awready_q, wready_q, bvalid_q, bresp_q, arready_q, rvalid_q,
                      rdata_q, rresp_q};

  // ==========================================================================
  // configuration registers; counters themselves are never written
  logic wr_cs, wr_cc, wr_es, wr_if, wr_ie, rd_cs;
  assign wr_cs = wr_en && (awaddr_q == aec_pkg::OFS_CTL_STATUS);
  assign wr_cc = wr_en && (awaddr_q == aec_pkg::OFS_CLK_CTL);
  assign wr_es = wr_en && (awaddr_q == aec_pkg::OFS_EDGE_SEL);
  assign wr_if = wr_en && (awaddr_q == aec_pkg::OFS_IRQ_FLAG);
  assign wr_ie = wr_en && (awaddr_q == aec_pkg::OFS_IRQ_EN);
  assign rd_cs = ar_take && (rd_addr == aec_pkg::OFS_CTL_STATUS);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {rsvd_q, chan_q, hce_q, lce_q, hrc_q, lrc_q} <= aec_pkg::RST_CTL_STATUS[5:0];
      {hsel_q, lsel_q} <= aec_pkg::RST_CLK_CTL[7:4];
      {hedge_q, ledge_q, gedge_q} <= aec_pkg::RST_EDGE_SEL[7:2];
      pwm_en_q <= aec_pkg::RST_EDGE_SEL[aec_pkg::ES_PWM_EN];
      {gen_q, cen_q} <= 2'h0;
    end
    else
    begin
      if (wr_cs)
      begin
        rsvd_q <= wdata_q[aec_pkg::CS_RSVD];
        chan_q <= wdata_q[aec_pkg::CS_CHAN];
        hce_q <= wdata_q[aec_pkg::CS_HIGH_CE];
        lce_q <= wdata_q[aec_pkg::CS_LOW_CE];
        hrc_q <= wdata_q[aec_pkg::CS_HIGH_RC];
        lrc_q <= wdata_q[aec_pkg::CS_LOW_RC];
      end
      if (wr_cc)
      begin
        hsel_q <= wdata_q[aec_pkg::CC_HIGH_SEL +: 2];
        lsel_q <= wdata_q[aec_pkg::CC_LOW_SEL +: 2];
      end
      if (wr_es)
      begin
        hedge_q <= wdata_q[aec_pkg::ES_HIGH_EDGE +: 2];
        ledge_q <= wdata_q[aec_pkg::ES_LOW_EDGE +: 2];
        gedge_q <= wdata_q[aec_pkg::ES_GATE_EDGE +: 2];
        pwm_en_q <= wdata_q[aec_pkg::ES_PWM_EN];
      end
      if (wr_ie)
      begin
        cen_q <= wdata_q[aec_pkg::IRQ_COUNT];
        gen_q <= wdata_q[aec_pkg::IRQ_GATE];
      end
    end
  end

  // ==========================================================================
  // counting
  logic gate_ok, lo_tick, lo_wrap, hi_tick, hi_wrap, hi_ovf_set, lo_ovf_set;
  // gating cuts ticks outright, so a count may be lost right at a gate edge
  assign gate_ok = pwm_en_q ? filt_q[3] : filt_q[2];
  assign lo_tick = gate_ok & lce_q & lrc_q &
                   src_tick(lsel_q, edge_hit(ledge_q, rise[1], fall[1]), pre_q);
  assign lo_wrap = lo_tick && (cnt_lo_q == aec_pkg::COUNT_MAX);
  assign hi_tick = chan_q ?
                   (gate_ok & hce_q &
                    src_tick(hsel_q, edge_hit(hedge_q, rise[0], fall[0]), pre_q)) :
                   lo_wrap;
  assign hi_wrap = hi_tick && hrc_q && (cnt_hi_q == aec_pkg::COUNT_MAX);
  assign hi_ovf_set = hi_wrap;
  assign lo_ovf_set = chan_q & lo_wrap;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !hrc_q)
      cnt_hi_q <= aec_pkg::RST_COUNT;
    else if (hi_tick)
      cnt_hi_q <= cnt_hi_q + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !lrc_q)
      cnt_lo_q <= aec_pkg::RST_COUNT;
    else if (lo_tick)
      cnt_lo_q <= cnt_lo_q + 8'h01;
  end

  // ==========================================================================
  // overflow flags: set wins over a clear in the same cycle
  logic hi_clr, lo_clr;
  assign hi_clr = wr_cs & ~wdata_q[aec_pkg::CS_HIGH_OVF] & hi_arm_q;
  assign lo_clr = wr_cs & ~wdata_q[aec_pkg::CS_LOW_OVF] & lo_arm_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hi_ovf_q <= aec_pkg::RST_CTL_STATUS[aec_pkg::CS_HIGH_OVF];
      lo_ovf_q <= aec_pkg::RST_CTL_STATUS[aec_pkg::CS_LOW_OVF];
      hi_arm_q <= 1'b0;
      lo_arm_q <= 1'b0;
    end
    else
    begin
      if (hi_ovf_set)
        hi_ovf_q <= 1'b1;
      else if (hi_clr)
        hi_ovf_q <= 1'b0;
      if (lo_ovf_set)
        lo_ovf_q <= 1'b1;
      else if (lo_clr)
        lo_ovf_q <= 1'b0;
      if (rd_cs && hi_ovf_q)
        hi_arm_q <= 1'b1;
      else if (hi_clr && !hi_ovf_set)
        hi_arm_q <= 1'b0;
      if (rd_cs && lo_ovf_q)
        lo_arm_q <= 1'b1;
      else if (lo_clr && !lo_ovf_set)
        lo_arm_q <= 1'b0;
    end
  end

  // ==========================================================================
  // interrupt flags and requests
  logic gate_evt;
  // with pwm gating on, the pwm output takes the gate pin's place as source
  assign gate_evt = pwm_en_q ? edge_hit(gedge_q, rise[3], fall[3]) :
                               edge_hit(gedge_q, rise[2], fall[2]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cirq_q <= 1'b0;
      girq_q <= 1'b0;
      counter_irq_o <= 1'b0;
      gate_irq_o <= 1'b0;
      gate_irq_vector_o <= aec_pkg::GATE_IRQ_VECTOR;
    end
    else
    begin
      if (hi_ovf_set || lo_ovf_set)
        cirq_q <= 1'b1;
      else if (wr_if && !wdata_q[aec_pkg::IRQ_COUNT])
        cirq_q <= 1'b0;
      if (gate_evt)
        girq_q <= 1'b1;
      else if (wr_if && !wdata_q[aec_pkg::IRQ_GATE])
        girq_q <= 1'b0;
      counter_irq_o <= cirq_q & cen_q;
      gate_irq_o <= girq_q & gen_q;
      gate_irq_vector_o <= aec_pkg::GATE_IRQ_VECTOR;
    end
  end

  // ==========================================================================
  // assertions
  property p_high_held;
    @(posedge clk_i) disable iff (rst_i) !hrc_q |=> (cnt_hi_q == 8'h00);
  endproperty
  a_high_held: assert property (p_high_held) else $error("high counter not held");

  property p_low_held;
    @(posedge clk_i) disable iff (rst_i) !lrc_q |=> (cnt_lo_q == 8'h00);
  endproperty
  a_low_held: assert property (p_low_held) else $error("low counter not held");

  property p_no_sw_set;
    @(posedge clk_i) disable iff (rst_i) (!hi_ovf_q && !hi_ovf_set) |=> !hi_ovf_q;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) else $error("high flag set by software");

  property p_clear_needs_read;
    @(posedge clk_i) disable iff (rst_i) (lo_ovf_q && !lo_arm_q) |=> lo_ovf_q;
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("unread flag cleared");

  property p_wrap16;
    @(posedge clk_i) disable iff (rst_i)
      (!chan_q && lo_tick && hrc_q && {cnt_hi_q, cnt_lo_q} == 16'hFFFF)
      |=> ({cnt_hi_q, cnt_lo_q} == 16'h0000) && hi_ovf_q && !$past(lo_ovf_set);
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong");

  property p_wrap8_low;
    @(posedge clk_i) disable iff (rst_i)
      (chan_q && lo_tick && cnt_lo_q == 8'hFF) |=> (cnt_lo_q == 8'h00) && lo_ovf_q;
  endproperty
  a_wrap8_low: assert property (p_wrap8_low) else $error("8-bit low wrap wrong");

  property p_enable_hold;
    @(posedge clk_i) disable iff (rst_i) (!lce_q && lrc_q) |=> $stable(cnt_lo_q);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("low moved while disabled");

  property p_gate_hold;
    @(posedge clk_i) disable iff (rst_i)
      (!pwm_en_q && !filt_q[2] && hrc_q && lrc_q) |=> $stable(cnt_lo_q) && $stable(cnt_hi_q);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("counted with gate low");

  property p_irq_out;
    @(posedge clk_i) disable iff (rst_i)
      (hi_ovf_set || lo_ovf_set) |=> cirq_q ##1 (counter_irq_o == $past(cen_q));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("overflow request wrong");

endmodule

// *** sim/aec_pin_model.sv ***
// aec_pin_model: event pulse sources and gate levels outside the counter
`timescale 1ns/1ps
module aec_pin_model
(
  // clock
  input wire logic clk_i,
  // gate levels from the bench
  input wire logic gate_i,
  input wire logic pwm_i,
  // pins towards the counter
  output aec_pkg::aec_pins_s pins_o
);
  // ==========================================================================
  // pin drive
  logic [1:0] ev_q;
  // one gate level feeds both counters, never one alone
  assign pins_o = '{pwm:pwm_i, gate:gate_i, low_event:ev_q[0], high_event:ev_q[1]};
  initial
  begin
    ev_q = 2'h3;
  end
  // event pins idle high; four cycles each way stays above the pin filter width
  task automatic pulse(input logic [1:0] m, input int n);
    begin
      repeat (n)
      begin
        @(posedge clk_i);
        ev_q <= ~m;
        repeat (4) @(posedge clk_i);
        ev_q <= 2'h3;
        repeat (4) @(posedge clk_i);
      end
    end
  endtask
endmodule

// *** sim/test_aec_counter.sv ***
// test_aec_counter: self-checking bench of the event counter through its register bus
`timescale 1ns/1ps
module test_aec_counter;
  // ==========================================================================
  // signals
  localparam logic [7:0] CS = aec_pkg::OFS_CTL_STATUS;
  localparam logic [7:0] CK = aec_pkg::OFS_CLK_CTL;
  localparam logic [7:0] ES = aec_pkg::OFS_EDGE_SEL;
  localparam logic [7:0] CH = aec_pkg::OFS_COUNT_HIGH;
  localparam logic [7:0] CL = aec_pkg::OFS_COUNT_LOW;
  localparam logic [7:0] FLG = aec_pkg::OFS_IRQ_FLAG;
  localparam logic [7:0] IEN = aec_pkg::OFS_IRQ_EN;
  logic clk_i;
  logic rst_i;
  logic gate;
  logic pwm;
  logic counter_irq;
  logic gate_irq;
  logic [7:0] vec;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [1:0] wr_resp;
  logic [31:0] hv;
  int err_count;
  int tests_run;
  aec_pkg::aec_axi_req_s req;
  aec_pkg::aec_axi_rsp_s rsp;
  aec_pkg::aec_pins_s pins;

  aec_counter uut (.clk_i(clk_i), .rst_i(rst_i), .axi_req_i(req), .axi_rsp_o(rsp),
    .pins_i(pins), .counter_irq_o(counter_irq), .gate_irq_o(gate_irq),
    .gate_irq_vector_o(vec));
  aec_pin_model pm (.clk_i(clk_i), .gate_i(gate), .pwm_i(pwm), .pins_o(pins));

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
        err_count = err_count + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    begin
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk_i);
      req <= '{awvalid:1'b1, awaddr:a, wvalid:1'b1, wdata:{24'h00_0000, d},
        wstrb:4'hF, bready:1'b1, default:'0};
      while (!(aw_ok && w_ok))
      begin
        @(posedge clk_i);
        aw_ok = aw_ok || rsp.awready === 1'b1;
        w_ok = w_ok || rsp.wready === 1'b1;
        req.awvalid <= req.awvalid && !aw_ok;
        req.wvalid <= req.wvalid && !w_ok;
      end
      do @(posedge clk_i); while (rsp.bvalid !== 1'b1);
      wr_resp = rsp.bresp;
      req.bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    begin
      @(posedge clk_i);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do @(posedge clk_i); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge clk_i); while (rsp.rvalid !== 1'b1);
      rd_data = rsp.rdata;
      rd_resp = rsp.rresp;
      req.rready <= 1'b0;
    end
  endtask
  // gate levels pass a filter, so let them settle before counting
  task automatic set_gate(input logic g, input logic p);
    begin
      @(posedge clk_i);
      gate <= g;
      pwm <= p;
      repeat (10) @(posedge clk_i);
    end
  endtask
  task automatic pulse_rd(input logic [1:0] m, input int n, input logic [7:0] a);
    begin
      pm.pulse(m, n);
      repeat (10) @(posedge clk_i);
      rd(a);
    end
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    begin
      for (int i = 0; i < 7; i++)
      begin
        rd(8'(i * 4));
        check(rd_data, 32'h0000_0000);
      end
      check(32'(rd_resp), 32'(aec_pkg::AXI_OKAY));
      rd(8'h1C);
      check(32'(rd_resp), 32'(aec_pkg::AXI_SLVERR));
      // unmapped write answers with an error and changes nothing
      wr(8'h1C, 8'hFF);
      check(32'(wr_resp), 32'(aec_pkg::AXI_SLVERR));
      wr(CK, 8'h00);
      check(32'(wr_resp), 32'(aec_pkg::AXI_OKAY));
      check(32'(vec), 32'(aec_pkg::GATE_IRQ_VECTOR));
    end
  endtask
  task automatic t_hold;
    begin
      set_gate(1'b1, 1'b0);
      wr(CK, 8'h50);
      wr(CS, 8'h1C);
      repeat (40) @(posedge clk_i);
      rd(CH);
      check(rd_data, 32'h0000_0000);
      rd(CL);
      check(rd_data, 32'h0000_0000);
    end
  endtask
  // high on clock/8, low on clock/2 for about 84 cycles
  task automatic t_ratio;
    begin
      wr(CK, 8'hD0);
      wr(CS, 8'h1F);
      repeat (80) @(posedge clk_i);
      wr(CS, 8'h13);
      wr(CH, 8'h00);
      rd(CH);
      hv = rd_data;
      check(32'(rd_data >= 9 && rd_data <= 12), 32'h1);
      rd(CL);
      check(32'(rd_data >= 40 && rd_data <= 48), 32'h1);
      wr(CS, 8'h12);
      rd(CL);
      check(rd_data, 32'h0000_0000);
      rd(CH);
      check(rd_data, hv);
    end
  endtask
  task automatic t_ovf;
    begin
      wr(CS, 8'h10);
      wr(CK, 8'h90);
      wr(CS, 8'h1F);
      repeat (1100) @(posedge clk_i);
      wr(CS, 8'h13);
      rd(CS);
      check(rd_data, 32'h0000_00D3);
      rd(FLG);
      check(rd_data, 32'h0000_0001);
      check(32'(counter_irq), 32'h0);
      wr(IEN, 8'h01);
      repeat (2) @(posedge clk_i);
      check(32'(counter_irq), 32'h1);
      wr(CS, 8'hD3);
      rd(CS);
      check(rd_data, 32'h0000_00D3);
      wr(CS, 8'h13);
      rd(CS);
      check(rd_data, 32'h0000_0013);
      wr(CS, 8'hD3);
      rd(CS);
      check(rd_data, 32'h0000_0013);
      wr(FLG, 8'h00);
      repeat (2) @(posedge clk_i);
      check(32'(counter_irq), 32'h0);
    end
  endtask
  task automatic t_gate;
    begin
      wr(ES, 8'h04);
      set_gate(1'b0, 1'b0);
      wr(FLG, 8'h00);
      wr(IEN, 8'h02);
      repeat (2) @(posedge clk_i);
      check(32'(gate_irq), 32'h0);
      set_gate(1'b1, 1'b0);
      check(32'(gate_irq), 32'h1);
      wr(FLG, 8'h00);
      repeat (2) @(posedge clk_i);
      check(32'(gate_irq), 32'h0);
    end
  endtask
  // a low byte wrap in cascade carries into the high byte without a flag
  task automatic t_cascade;
    begin
      wr(CS, 8'h00);
      wr(CK, 8'h10);
      wr(CS, 8'h07);
      repeat (600) @(posedge clk_i);
      wr(CS, 8'h03);
      rd(CH);
      check(rd_data, 32'h0000_0001);
      rd(CS);
      check(rd_data, 32'h0000_0003);
    end
  endtask
  task automatic t_pins;
    begin
      wr(CS, 8'h00);
      wr(CK, 8'h00);
      wr(ES, 8'h00);
      wr(CS, 8'h07);
      pulse_rd(2'h1, 5, CL);
      check(rd_data, 32'h0000_0005);
      wr(ES, 8'h10);
      pulse_rd(2'h1, 2, CL);
      check(rd_data, 32'h0000_0007);
      wr(ES, 8'h20);
      pulse_rd(2'h1, 2, CL);
      check(rd_data, 32'h0000_000B);
      set_gate(1'b0, 1'b0);
      pulse_rd(2'h1, 3, CL);
      check(rd_data, 32'h0000_000B);
      set_gate(1'b0, 1'b1);
      wr(ES, 8'h21);
      pulse_rd(2'h1, 2, CL);
      check(rd_data, 32'h0000_000F);
      wr(CS, 8'h03);
      pulse_rd(2'h1, 2, CL);
      check(rd_data, 32'h0000_000F);
      set_gate(1'b1, 1'b0);
      wr(CS, 8'h10);
      wr(CS, 8'h1A);
      wr(ES, 8'h40);
      pulse_rd(2'h2, 3, CH);
      check(rd_data, 32'h0000_0003);
    end
  endtask

  // ==========================================================================
  // clock, reset, sequence and timeout
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    gate = 1'b0;
    pwm = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset();
    t_hold();
    t_ratio();
    t_ovf();
    t_gate();
    t_cascade();
    t_pins();
    summarize();
  end
  // the whole sequence needs well under 10000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    err_count = err_count + 1;
    summarize();
  end
endmodule
